// file: core/nvs_pkg.sv
/*
  Shared types and constants for the host-side controller of a 32K x 8
  nonvolatile SRAM: pin groups, command codes, timing figures and the
  cycle counts derived from them.
  Assumes a 40 MHz system clock and a device of the slowest speed grade.
*/
// Behaviour
// R1: Write strobe stays high during every read.
// R2: Hardware store line stays high during accesses.
// R3: Device ignores accesses during nonvolatile work, brownout.
// R4: Power-up restore finishes within twenty milliseconds.
// R5: Store finishes within 12.5 or 15 ms.
// R6: No store happens without a write since.
// R7: Sequence advances on each falling read edge.
// R8: Six reads at fixed addresses, strobe high.
// R9: Each sequence read lasts the speed-grade minimum.
// R10: Sequence command takes up to seventy microseconds.
// R11: Device blocks accesses until commanded work ends.
package nvs_pkg;

  // ==========================================================================
  // Pin and command carriers
  // ==========================================================================
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [14:0] addr;
  } nvs_pins_s;

  typedef enum logic [2:0] {
    NVS_OP_READ,
    NVS_OP_WRITE,
    NVS_OP_SW_STORE,
    NVS_OP_SW_RECALL,
    NVS_OP_HW_STORE
  } nvs_op_e;

  typedef struct packed {
    nvs_op_e op;
    logic [14:0] addr;
    logic [7:0] wdata;
  } nvs_cmd_s;

  localparam nvs_pins_s NVS_PINS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 15'h0000};

  // ==========================================================================
  // Timing figures as printed, and cycle counts at 40 MHz
  // ==========================================================================
  localparam real NVS_CLK_MHZ = 40.0;
  localparam real NVS_READ_CYCLE_NS = 45.0;
  localparam real NVS_WRITE_PULSE_NS = 30.0;
  localparam real NVS_HW_STORE_PULSE_NS = 15.0;
  localparam real NVS_POWERUP_RESTORE_TIME_MS = 20.0;
  localparam real NVS_STORE_TIME_COM_MS = 12.5;
  localparam real NVS_STORE_TIME_IND_MS = 15.0;
  localparam real NVS_SOFT_SEQ_TIME_US = 70.0;
  localparam real NVS_RECALL_TIME_US = 120.0;

  localparam int NVS_SYNC_STAGES = 2;
  localparam int NVS_RD_CYC = int'($ceil(NVS_READ_CYCLE_NS * NVS_CLK_MHZ / 1000.0));
  localparam int NVS_RD_HOLD_CYC = NVS_RD_CYC + NVS_SYNC_STAGES;
  localparam int NVS_WR_CYC = int'($ceil(NVS_WRITE_PULSE_NS * NVS_CLK_MHZ / 1000.0));
  localparam int NVS_HWS_CYC = int'($ceil(NVS_HW_STORE_PULSE_NS * NVS_CLK_MHZ / 1000.0));
  localparam int NVS_GAP_CYC = 1;
  localparam int NVS_SS_CYC = int'($ceil(NVS_SOFT_SEQ_TIME_US * NVS_CLK_MHZ));
  localparam int NVS_PWRUP_CYC = int'($ceil(NVS_POWERUP_RESTORE_TIME_MS * NVS_CLK_MHZ * 1000.0));
  localparam int NVS_STORE_CYC = int'($ceil(NVS_STORE_TIME_IND_MS * NVS_CLK_MHZ * 1000.0));
  localparam int NVS_STORE_COM_CYC = int'($ceil(NVS_STORE_TIME_COM_MS * NVS_CLK_MHZ * 1000.0));
  localparam int NVS_RECALL_CYC = int'($ceil(NVS_RECALL_TIME_US * NVS_CLK_MHZ));

  localparam int NVS_TMR_W = 21;
  localparam int NVS_SEQ_LEN = 6;

  // ==========================================================================
  // Software sequence addresses; the last entry selects store or recall
  // ==========================================================================
  typedef logic [14:0] nvs_seq_t [NVS_SEQ_LEN];
  localparam nvs_seq_t NVS_SEQ_ADDR = '{15'h0e38, 15'h31c7, 15'h03e0, 15'h3c1f,
                                        15'h303f, 15'h0fc0};
  localparam logic [14:0] NVS_SEQ_STORE_LAST = 15'h0fc0;
  localparam logic [14:0] NVS_SEQ_RECALL_LAST = 15'h0c63;

endpackage : nvs_pkg

// file: core/nvs_timer.sv
/*
  Down-counter used by the controller for every timed wait; S_BUSY waits on the store line instead.
  Assumes the loaded count is at least one; expired is high while idle.
*/
module nvs_timer (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [nvs_pkg::NVS_TMR_W-1:0] count,
  output logic expired
);
  import nvs_pkg::*;

  logic [NVS_TMR_W-1:0] cnt_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= count;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign expired = (cnt_q == '0);

endmodule : nvs_timer

// file: core/nvs_host.sv
/*
  Host controller that drives a 32K x 8 nonvolatile SRAM through its
  asynchronous pins: plain reads and writes, the six-read software
  store/recall sequence and a hardware store request, with the waits
  the device needs after power-up and nonvolatile work.
  Assumes the data bus and the hardware store line are resolved outside
  from the enables, and that power_ok_pin reports the supply threshold.
*/
module nvs_host #(
  parameter int PWRUP_CYC = nvs_pkg::NVS_PWRUP_CYC,
  parameter int STORE_CYC = nvs_pkg::NVS_STORE_CYC,
  parameter int RECALL_CYC = nvs_pkg::NVS_RECALL_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input nvs_pkg::nvs_cmd_s cmd,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_rdata,
  output logic dirty,
  output nvs_pkg::nvs_pins_s pins,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  input wire logic hw_store_req_n_in,
  output logic hw_store_req_n_out,
  output logic hw_store_req_n_oe,
  input wire logic power_ok_pin
);
  import nvs_pkg::*;

  typedef enum {
    S_PWRUP, S_IDLE, S_RD, S_GAP, S_WR, S_WHOLD, S_HWS, S_NV, S_BUSY
  } nvs_state_e;

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  logic [7:0] data_m_q, data_s_q;
  logic hws_m_q, hws_s_q, pwr_m_q, pwr_s_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_m_q <= 8'h00;
      data_s_q <= 8'h00;
      hws_m_q <= 1'b1;
      hws_s_q <= 1'b1;
      pwr_m_q <= 1'b0;
      pwr_s_q <= 1'b0;
    end else begin
      data_m_q <= data_in;
      data_s_q <= data_m_q;
      hws_m_q <= hw_store_req_n_in;
      hws_s_q <= hws_m_q;
      pwr_m_q <= power_ok_pin;
      pwr_s_q <= pwr_m_q;
    end
  end

  // ==========================================================================
  // Timer
  // ==========================================================================
  logic tmr_load_q;
  logic [NVS_TMR_W-1:0] tmr_count_q;
  logic tmr_expired;
  logic tmr_done;

  nvs_timer u_timer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .load(tmr_load_q),
    .count(tmr_count_q),
    .expired(tmr_expired)
  );

  // The load takes effect one edge late, so a stale expiry is masked.
  assign tmr_done = tmr_expired && !tmr_load_q;

  function automatic logic [NVS_TMR_W-1:0] cyc(input int n);
    cyc = NVS_TMR_W'(n);
  endfunction : cyc

  function automatic logic [14:0] seq_addr(input logic [2:0] idx, input logic recall);
    if (idx == 3'(NVS_SEQ_LEN - 1)) begin
      seq_addr = recall ? NVS_SEQ_RECALL_LAST : NVS_SEQ_STORE_LAST;
    end else begin
      seq_addr = NVS_SEQ_ADDR[idx];
    end
  endfunction : seq_addr

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  nvs_state_e state_q;
  nvs_cmd_s cmd_q;
  nvs_pins_s pins_q;
  logic [2:0] seq_idx_q;
  logic seq_q;
  logic dirty_q;
  logic ready_q, rsp_valid_q;
  logic [7:0] rdata_q, dout_q;
  logic doe_q, hws_oe_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= S_PWRUP;
      cmd_q <= '0;
      pins_q <= NVS_PINS_IDLE;
      seq_idx_q <= 3'h0;
      seq_q <= 1'b0;
      ready_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rdata_q <= 8'h00;
      dout_q <= 8'h00;
      doe_q <= 1'b0;
      hws_oe_q <= 1'b0;
      tmr_load_q <= 1'b1;
      tmr_count_q <= NVS_TMR_W'(PWRUP_CYC);
    end else begin
      tmr_load_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      unique case (state_q)
        S_PWRUP: begin
          // A supply dip restarts the restore wait from the top.
          if (!pwr_s_q) begin
            tmr_load_q <= 1'b1; // [R3]
            tmr_count_q <= cyc(PWRUP_CYC); // [R4]
          end else if (tmr_done && hws_s_q) begin
            state_q <= S_IDLE;
            ready_q <= 1'b1;
          end
        end
        S_IDLE: begin
          if (!pwr_s_q) begin
            state_q <= S_PWRUP; // [R3]
            ready_q <= 1'b0;
            tmr_load_q <= 1'b1;
            tmr_count_q <= cyc(PWRUP_CYC); // [R4]
          end else if (!hws_s_q) begin
            // A store started elsewhere owes the command port no response.
            state_q <= S_BUSY; // [R3]
            ready_q <= 1'b0;
            cmd_q.op <= NVS_OP_READ;
          end else if (cmd_valid) begin
            ready_q <= 1'b0;
            cmd_q <= cmd;
            seq_idx_q <= 3'h0;
            tmr_load_q <= 1'b1;
            unique case (cmd.op)
              NVS_OP_READ: begin
                seq_q <= 1'b0;
                pins_q <= '{ce_n: 1'b0, oe_n: 1'b0, we_n: 1'b1, addr: cmd.addr}; // [R1] [R2]
                tmr_count_q <= cyc(NVS_RD_HOLD_CYC);
                state_q <= S_RD;
              end
              NVS_OP_WRITE: begin
                pins_q <= '{ce_n: 1'b0, oe_n: 1'b1, we_n: 1'b0, addr: cmd.addr}; // [R2]
                dout_q <= cmd.wdata;
                doe_q <= 1'b1;
                tmr_count_q <= cyc(NVS_WR_CYC);
                state_q <= S_WR;
              end
              NVS_OP_SW_STORE, NVS_OP_SW_RECALL: begin
                seq_q <= 1'b1;
                pins_q <= '{ce_n: 1'b0, oe_n: 1'b0, we_n: 1'b1,
                            addr: seq_addr(3'h0, cmd.op == NVS_OP_SW_RECALL)}; // [R8]
                tmr_count_q <= cyc(NVS_RD_HOLD_CYC); // [R9]
                state_q <= S_RD;
              end
              NVS_OP_HW_STORE: begin
                hws_oe_q <= 1'b1;
                tmr_count_q <= cyc(NVS_HWS_CYC);
                state_q <= S_HWS;
              end
              default: begin
                rsp_valid_q <= 1'b1;
                ready_q <= 1'b1;
              end
            endcase
          end
        end
        S_RD: begin
          if (tmr_done) begin
            // Releasing both strobes gives the next read a fresh falling edge.
            pins_q.ce_n <= 1'b1; // [R7]
            pins_q.oe_n <= 1'b1;
            rdata_q <= data_s_q;
            tmr_load_q <= 1'b1;
            tmr_count_q <= cyc(NVS_GAP_CYC);
            state_q <= S_GAP;
          end
        end
        S_GAP: begin
          if (tmr_done) begin
            if (seq_q && seq_idx_q != 3'(NVS_SEQ_LEN - 1)) begin
              seq_idx_q <= seq_idx_q + 3'h1;
              pins_q <= '{ce_n: 1'b0, oe_n: 1'b0, we_n: 1'b1,
                          addr: seq_addr(seq_idx_q + 3'h1,
                                         cmd_q.op == NVS_OP_SW_RECALL)}; // [R7] [R8]
              tmr_load_q <= 1'b1;
              tmr_count_q <= cyc(NVS_RD_HOLD_CYC); // [R9]
              state_q <= S_RD;
            end else if (seq_q) begin
              tmr_load_q <= 1'b1;
              if (cmd_q.op == NVS_OP_SW_RECALL) begin
                tmr_count_q <= cyc(NVS_SS_CYC + RECALL_CYC); // [R10] [R11]
              end else if (dirty_q) begin
                tmr_count_q <= cyc(NVS_SS_CYC + STORE_CYC); // [R5] [R10] [R11]
              end else begin
                tmr_count_q <= cyc(NVS_SS_CYC); // [R6] [R10]
              end
              state_q <= S_NV;
            end else begin
              rsp_valid_q <= 1'b1;
              ready_q <= 1'b1;
              state_q <= S_IDLE;
            end
          end
        end
        S_WR: begin
          if (tmr_done) begin
            pins_q.we_n <= 1'b1;
            pins_q.ce_n <= 1'b1;
            tmr_load_q <= 1'b1;
            tmr_count_q <= cyc(NVS_GAP_CYC);
            state_q <= S_WHOLD;
          end
        end
        S_WHOLD: begin
          if (tmr_done) begin
            doe_q <= 1'b0;
            rsp_valid_q <= 1'b1;
            ready_q <= 1'b1;
            state_q <= S_IDLE;
          end
        end
        S_HWS: begin
          if (tmr_done) begin
            hws_oe_q <= 1'b0;
            tmr_load_q <= 1'b1;
            tmr_count_q <= dirty_q ? cyc(STORE_CYC) : cyc(NVS_GAP_CYC); // [R5] [R6]
            state_q <= S_NV;
          end
        end
        S_NV: begin
          if (tmr_done) begin
            state_q <= S_BUSY; // [R11]
          end
        end
        S_BUSY: begin
          // The device holds the store line low while it is still busy.
          if (hws_s_q) begin
            rsp_valid_q <= seq_or_hws(cmd_q.op);
            ready_q <= 1'b1;
            state_q <= S_IDLE; // [R11]
          end
        end
      endcase
    end
  end

  function automatic logic seq_or_hws(input nvs_op_e op);
    seq_or_hws = (op == NVS_OP_SW_STORE) || (op == NVS_OP_SW_RECALL) ||
                 (op == NVS_OP_HW_STORE);
  endfunction : seq_or_hws

  // ==========================================================================
  // Dirty tracking
  // ==========================================================================
  // Cleared when this controller launches a store or recall (not on an external store), so a write that lands
  // later still forces the next store to be waited out in full.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dirty_q <= 1'b1;
    end else if (state_q == S_IDLE && cmd_valid && pwr_s_q && hws_s_q &&
                 cmd.op == NVS_OP_WRITE) begin
      dirty_q <= 1'b1;
    end else if ((state_q == S_GAP && tmr_done && seq_q &&
                  seq_idx_q == 3'(NVS_SEQ_LEN - 1)) ||
                 (state_q == S_HWS && tmr_done)) begin
      dirty_q <= 1'b0; // [R6]
    end
  end

  assign cmd_ready = ready_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp_rdata = rdata_q;
  assign dirty = dirty_q;
  assign pins = pins_q;
  assign data_out = dout_q;
  assign data_oe = doe_q;
  assign hw_store_req_n_out = 1'b0;
  assign hw_store_req_n_oe = hws_oe_q; // [R2]

endmodule : nvs_host

// file: testbench/nvs_host_sva.sv
/* Assertions on the host controller's pins and command port.
   Bound to every nvs_host instance and sees only its ports. */
module nvs_host_sva (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input nvs_pkg::nvs_cmd_s cmd,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic dirty,
  input nvs_pkg::nvs_pins_s pins,
  input wire logic hw_store_req_n_in,
  input wire logic hw_store_req_n_oe,
  input wire logic power_ok_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  import nvs_pkg::*;
  // ==========================================
  // Pin and port properties
  // ==========================================
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_rd_take;
    cmd_valid && cmd_ready && cmd.op == NVS_OP_READ;
  endsequence
  sequence s_rd_strobe;
    (!pins.ce_n && !pins.oe_n && pins.we_n) [*2];
  endsequence
  a_rd_launch: assert property (s_rd_take |-> ##[1:3] s_rd_strobe)
    else $error("read strobes late or short");
  a_rd_we_high: assert property (!pins.ce_n && !pins.oe_n |-> pins.we_n)
    else $error("write strobe low in a read");
  a_access_store_high: assert property (!pins.ce_n |-> !hw_store_req_n_oe)
    else $error("store line pulled during access");
  a_strobe_width: assert property ($fell(pins.ce_n) |-> !pins.ce_n [*2])
    else $error("select pulse too short");
  a_addr_held: assert property (!pins.ce_n && $past(!pins.ce_n) |-> $stable(pins.addr))
    else $error("address moved during access");
  // Five cycles cover the two sync flops and the ready register.
  a_power_block: assert property (!power_ok_pin [*5] |-> !cmd_ready)
    else $error("ready with supply low");
  a_line_block: assert property (!hw_store_req_n_in [*5] |-> !cmd_ready)
    else $error("ready while store line low");
  a_dirty_write: assert property (!pins.we_n |-> ##[0:3] dirty)
    else $error("write not marked dirty");
  a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
    else $error("response longer than a cycle");
endmodule : nvs_host_sva

bind nvs_host nvs_host_sva u_nvs_host_sva (
  .sys_clk(sys_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
  .rsp_valid(rsp_valid), .dirty(dirty), .pins(pins), .hw_store_req_n_in(hw_store_req_n_in),
  .hw_store_req_n_oe(hw_store_req_n_oe), .power_ok_pin(power_ok_pin)
);

// file: testbench/nvs_dev_model.sv
/* Behavioural model of the nonvolatile SRAM seen from its pins.
   Samples the host's registered pins on the host clock; waits are shortened. */
module nvs_dev_model #(
  parameter int RESTORE_CYC = 40,
  parameter int SS_CYC = 100,
  parameter int STORE_CYC = 80,
  parameter int RECALL_CYC = 15
) (
  input wire logic sys_clk,
  input nvs_pkg::nvs_pins_s pins,
  input wire logic [7:0] dq_in,
  input wire logic power_ok,
  input wire logic store_line,
  output logic [7:0] dq_out,
  output logic dq_oe,
  output logic pull_low
);
  timeunit 1ns;
  timeprecision 100ps;
  import nvs_pkg::*;
  logic [7:0] sram [32768] = '{default: 8'h00};
  logic [7:0] nv [32768] = '{default: 8'h00};
  nvs_pins_s prev = NVS_PINS_IDLE;
  logic prev_pwr = 1'b0;
  logic prev_line = 1'b1;
  logic wrote = 1'b0;
  logic restoring = 1'b0;
  int busy_cnt = 0;
  int seq_pos = 0;
  int stores = 0;
  int skips = 0;
  int recalls = 0;
  // A read is served only with the supply up and no nonvolatile work running.
  assign dq_oe = power_ok && busy_cnt == 0 && !pins.ce_n && !pins.oe_n && pins.we_n;
  assign dq_out = sram[pins.addr];
  assign pull_low = busy_cnt > 0 && !restoring;

  task automatic launch_store(input int extra);
    if (wrote) begin
      nv = sram;
      stores++;
      wrote = 1'b0;
      busy_cnt = extra + STORE_CYC;
    end else begin
      skips++;
      busy_cnt = extra + 1;
    end
  endtask : launch_store

  task automatic seq_step(input logic [14:0] a);
    if (seq_pos < NVS_SEQ_LEN - 1) begin
      if (a == NVS_SEQ_ADDR[seq_pos]) seq_pos++;
      else seq_pos = (a == NVS_SEQ_ADDR[0]) ? 1 : 0;
    end else begin
      seq_pos = 0;
      if (a == NVS_SEQ_STORE_LAST) launch_store(SS_CYC);
      else if (a == NVS_SEQ_RECALL_LAST) begin
        sram = nv;
        wrote = 1'b0;
        recalls++;
        busy_cnt = SS_CYC + RECALL_CYC;
      end
    end
  endtask : seq_step

  always @(posedge sys_clk) begin
    if (!power_ok) begin
      seq_pos = 0;
    end else if (!prev_pwr) begin
      sram = nv;
      wrote = 1'b0;
      restoring = 1'b1;
      busy_cnt = RESTORE_CYC;
    end else if (busy_cnt > 0) begin
      busy_cnt--;
    end else begin
      restoring = 1'b0;
      if (!prev.we_n && !prev.ce_n && (pins.we_n || pins.ce_n)) begin
        sram[prev.addr] = dq_in;
        wrote = 1'b1;
        seq_pos = 0;
      end
      if (pins.we_n && !pins.ce_n && !pins.oe_n && (prev.ce_n || prev.oe_n)) seq_step(pins.addr);
      if (!store_line && prev_line) launch_store(0);
    end
    prev = pins;
    prev_pwr = power_ok;
    prev_line = store_line;
  end
endmodule : nvs_dev_model

// file: testbench/tb.sv
/* Self-checking bench for the host controller facing the device model.
   Inputs change 2 ns after each rising edge of the 40 MHz clock. */
`define CHK(got, exp) begin \
  tests_run++; \
  if ((got) !== (exp)) begin \
    mismatches++; \
    $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp); \
  end \
end

module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import nvs_pkg::*;
  localparam int PWRUP = 50;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic power_ok = 1'b0;
  nvs_cmd_s cmd = '0;
  logic cmd_ready, rsp_valid, dirty, data_oe, hws_out, hws_oe, dev_oe, dev_pull;
  logic [7:0] rsp_rdata, data_out, dev_q;
  logic [7:0] bus_last = 8'h00;
  nvs_pins_s pins;
  int mismatches = 0;
  int tests_run = 0;
  // A released bus shows the inverse of its last value, so a missed drive never reads as data.
  wire logic [7:0] bus = dev_oe ? dev_q : (data_oe ? data_out : ~bus_last);
  wire logic store_line = (hws_oe ? hws_out : 1'b1) && !dev_pull;
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) bus_last <= bus;

  nvs_host #(.PWRUP_CYC(PWRUP), .STORE_CYC(100), .RECALL_CYC(20)) u_nvs_host (
    .sys_clk(sys_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .dirty(dirty),
    .pins(pins), .data_in(bus), .data_out(data_out), .data_oe(data_oe),
    .hw_store_req_n_in(store_line), .hw_store_req_n_out(hws_out),
    .hw_store_req_n_oe(hws_oe), .power_ok_pin(power_ok)
  );
  nvs_dev_model u_nvs_dev_model (
    .sys_clk(sys_clk), .pins(pins), .dq_in(bus), .power_ok(power_ok),
    .store_line(store_line), .dq_out(dev_q), .dq_oe(dev_oe), .pull_low(dev_pull)
  );

  // ==========================================
  // Drivers and scenarios
  // ==========================================
  task automatic wait_ready(input logic lvl, output int n);
    n = 0;
    while (cmd_ready !== lvl && n < 1000) begin
      @(posedge sys_clk);
      #2;
      n++;
    end
  endtask : wait_ready

  task automatic do_cmd(input nvs_op_e op, input logic [14:0] a, input logic [7:0] d);
    int n;
    wait_ready(1'b1, n);
    cmd_valid = 1'b1;
    cmd = '{op: op, addr: a, wdata: d};
    @(posedge sys_clk);
    #2;
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 5000) begin
      @(posedge sys_clk);
      #2;
      n++;
    end
    `CHK(n < 5000, 1'b1)
  endtask : do_cmd

  task automatic rd_chk(input logic [14:0] a, input logic [7:0] exp);
    do_cmd(NVS_OP_READ, a, 8'h00);
    `CHK(rsp_rdata, exp)
  endtask : rd_chk

  task automatic t_powerup();
    int n;
    `CHK(cmd_ready, 1'b0)
    `CHK(dirty, 1'b1)
    `CHK(pins, NVS_PINS_IDLE)
    power_ok = 1'b1;
    wait_ready(1'b1, n);
    `CHK(n >= PWRUP && n < 1000, 1'b1)
  endtask : t_powerup

  task automatic t_nv_ops();
    do_cmd(NVS_OP_WRITE, 15'h0001, 8'h5a);
    do_cmd(NVS_OP_WRITE, 15'h7fff, 8'ha5);
    rd_chk(15'h0001, 8'h5a);
    rd_chk(15'h7fff, 8'ha5);
    do_cmd(NVS_OP_SW_STORE, 15'h0000, 8'h00);
    `CHK(u_nvs_dev_model.stores, 1)
    `CHK(dirty, 1'b0)
    do_cmd(NVS_OP_SW_STORE, 15'h0000, 8'h00);
    `CHK(u_nvs_dev_model.skips, 1)
    do_cmd(NVS_OP_WRITE, 15'h0001, 8'h3c);
    rd_chk(15'h0001, 8'h3c);
    do_cmd(NVS_OP_SW_RECALL, 15'h0000, 8'h00);
    `CHK(u_nvs_dev_model.recalls, 1)
    `CHK(dirty, 1'b0)
    rd_chk(15'h0001, 8'h5a);
    do_cmd(NVS_OP_WRITE, 15'h0002, 8'h77);
    do_cmd(NVS_OP_HW_STORE, 15'h0000, 8'h00);
    `CHK(u_nvs_dev_model.stores, 2)
  endtask : t_nv_ops

  task automatic t_brownout();
    int n;
    do_cmd(NVS_OP_WRITE, 15'h0002, 8'h11);
    power_ok = 1'b0;
    wait_ready(1'b0, n);
    `CHK(n < 8, 1'b1)
    repeat (20) @(posedge sys_clk);
    #2;
    power_ok = 1'b1;
    rd_chk(15'h0002, 8'h77);
  endtask : t_brownout

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    #500_000;
    mismatches++;
    complete_run();
  end

  initial begin
    repeat (10) @(posedge sys_clk);
    #2;
    rst_n = 1'b1;
    t_powerup();
    t_nv_ops();
    t_brownout();
    complete_run();
  end
endmodule : tb
